//--- rtl/dual_timer_pkg.sv
// Operation
// [RQ1] Sample count pins once per cycle at C4
// [RQ2] Source toggles no faster than clock/24
// [RQ3] Counts update at C3, edges next cycle
// [RQ4] Mode bits 2 and 6 pick clock/pin
// [RQ5] Rate bit: /12 when 0, /4 when 1
// [RQ6] Mode 0 is 13 bits wide
// [RQ7] Mode 0 carry and 1FFFh overflow flag
// [RQ8] Count only when run and gate pass
// [RQ9] Mode 1 is 16 bits, FFFFh overflow
// [RQ10] Mode 2 reloads low byte from high
// [RQ11] Second timer frozen in mode 3
// [RQ12] First timer splits into two bytes
// [RQ13] Second timer loses run and flag then
// [RQ14] Third timer source and run control
// [RQ15] Third timer 16-bit overflow sets flag
// [RQ16] Trigger edge captures count, sets flag
// [RQ17] Clear-on-capture zeroes third timer count
// [RQ18] Service acknowledge clears first two flags
// [RQ19] Third timer request is flag OR
// [RQ20] Mode bits are binary mode number
// [RQ21] Software writes take effect at once
package dual_timer_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_TIMER_MODE_REG  = 8'h00;
	localparam logic [7:0] ADDR_TCTL  = 8'h01;
	localparam logic [7:0] ADDR_CKCTL = 8'h02;
	localparam logic [7:0] ADDR_T0LO  = 8'h03;
	localparam logic [7:0] ADDR_T0HI  = 8'h04;
	localparam logic [7:0] ADDR_T1LO  = 8'h05;
	localparam logic [7:0] ADDR_T1HI  = 8'h06;
	localparam logic [7:0] ADDR_T2CTL = 8'h07;
	localparam logic [7:0] ADDR_T2_MODE_REG = 8'h08;
	localparam logic [7:0] ADDR_T2LO  = 8'h09;
	localparam logic [7:0] ADDR_T2HI  = 8'h0A;
	localparam logic [7:0] ADDR_CAPLO = 8'h0B;
	localparam logic [7:0] ADDR_CAPHI = 8'h0C;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MODE0_LSB = 0;
	localparam int CT0_BIT   = 2;
	localparam int GATE0_BIT = 3;
	localparam int MODE1_LSB = 4;
	localparam int CT1_BIT   = 6;
	localparam int GATE1_BIT = 7;
	localparam int TF1_BIT   = 7;
	localparam int TR1_BIT   = 6;
	localparam int TF0_BIT   = 5;
	localparam int TR0_BIT   = 4;
	localparam int T0M_BIT   = 3;
	localparam int T1M_BIT   = 4;
	localparam int T2M_BIT   = 5;
	localparam int TF2_BIT   = 7;
	localparam int T2_EXTERNAL_FLAG_BIT  = 6;
	localparam int EXEN_BIT  = 3;
	localparam int TR2_BIT   = 2;
	localparam int CT2_BIT   = 1;
	localparam int CPRL_BIT  = 0;
	localparam int CLRC_BIT  = 3;
	localparam int LO5_W     = 5;
	localparam int NPIN      = 4;
	// ----------------------------------------
	// Values and timing
	// ----------------------------------------
	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic [7:0] BYTE_ONE  = 8'h01;
	localparam logic [4:0] PRE_ONE   = 5'h01;
	localparam logic [15:0] WORD_ONE = 16'h0001;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [1:0] DIV3_LAST = 2'h2;
	localparam logic [1:0] DIV3_ONE  = 2'h1;
	localparam logic [1:0] DIV3_RST  = 2'h0;
	// Machine cycle phases
	typedef enum logic [1:0] {
		PH_C1 = 2'b00, PH_C2 = 2'b01, PH_C3 = 2'b10, PH_C4 = 2'b11
	} phase_t;
	// Timer modes, binary mode number
	typedef enum logic [1:0] {
		MODE_13B = 2'b00, MODE_16B = 2'b01, MODE_RLD = 2'b10, MODE_SPLIT = 2'b11
	} tmode_t;
	// Result of one count step
	typedef struct packed {
		logic       ovf;
		logic [7:0] hi;
		logic [7:0] lo;
	} cnt_t;
endpackage : dual_timer_pkg

//--- rtl/dual_timer_with_capture_timer.sv
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
module dual_timer_with_capture_timer
	import dual_timer_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Pins
	input  wire logic       count_pin_a,
	input  wire logic       count_pin_b,
	input  wire logic       count_pin_c,
	input  wire logic       t2_trigger_pin,
	input  wire logic       ext_irq_pin_a,
	input  wire logic       ext_irq_pin_b,
	// Interrupt service
	input  wire logic       t0_irq_ack,
	input  wire logic       t1_irq_ack,
	output logic            t0_irq,
	output logic            t1_irq,
	output logic            t2_irq
);
	// ----------------------------------------
	// Machine cycle phases
	// ----------------------------------------
	phase_t     phase_q, phase_d;
	logic [1:0] div3_q, div3_d, ticks;
	logic       is_c3, tick_slow;

	// Phase and divide-by-three counters
	always_comb begin
		phase_d = phase_t'(phase_q + 2'b01);
		div3_d  = div3_q;
		if (phase_q == PH_C4) begin
			div3_d = (div3_q == DIV3_LAST) ? DIV3_RST : div3_q + DIV3_ONE;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= PH_C1;
			div3_q  <= DIV3_RST;
		end else begin
			phase_q <= phase_d;
			div3_q  <= div3_d;
		end
	end

	assign is_c3     = (phase_q == PH_C3);                    // [RQ3]
	assign ticks     = {tick_slow, is_c3};
	assign tick_slow = is_c3 && (div3_q == DIV3_LAST);

	// Internal tick by rate bit
	function automatic logic int_tick(input logic fast, input logic [1:0] t);
		return fast ? t[0] : t[1];                             // [RQ5]
	endfunction : int_tick

	// ----------------------------------------
	// Pin edge detection
	// ----------------------------------------
	logic [NPIN-1:0] pin_in, samp_q, samp_d, prev_q, prev_d, fall;
	assign pin_in = {t2_trigger_pin, count_pin_c, count_pin_b, count_pin_a};

	// One sample per machine cycle at C4
	generate
		for (genvar i = 0; i < NPIN; i++) begin : g_pin
			always_comb begin
				samp_d[i] = samp_q[i];
				prev_d[i] = prev_q[i];
				if (phase_q == PH_C4) begin                          // [RQ1]
					samp_d[i] = pin_in[i];
					prev_d[i] = samp_q[i];
				end
			end
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					samp_q[i] <= 1'b0;
					prev_q[i] <= 1'b0;
				end else begin
					samp_q[i] <= samp_d[i];
					prev_q[i] <= prev_d[i];
				end
			end
			// High then low sample, used at next C3
			assign fall[i] = prev_q[i] & ~samp_q[i];               // [RQ1]
		end
	endgenerate

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] timer_mode_reg_q, timer_mode_reg_d, ck_q, ck_d, rd_q, rd_d;
	logic [7:0] t0_low_byte_q, t0_low_byte_d, t0_high_byte_q, t0_high_byte_d;
	logic [7:0] t1_low_byte_q, t1_low_byte_d, t1_high_byte_q, t1_high_byte_d;
	logic [7:0] t2_low_byte_q, t2_low_byte_d, t2_high_byte_q, t2_high_byte_d;
	logic [7:0] capture_low_byte_q, capture_low_byte_d;
	logic [7:0] capture_high_byte_q, capture_high_byte_d;
	logic       tf0_q, tf0_d, tf1_q, tf1_d, tr0_q, tr0_d, tr1_q, tr1_d;
	logic       tf2_q, tf2_d, t2_external_flag_q, t2_external_flag_d, t2irq_q, t2irq_d;
	logic       exen_q, exen_d, tr2_q, tr2_d, ct2_q, ct2_d, cprl_q, cprl_d;
	logic       clrc_q, clrc_d;

	// Write select
	function automatic logic wr_at(input logic [7:0] off);
		return reg_wr && (reg_addr == off);
	endfunction : wr_at

	// ----------------------------------------
	// Timers 0 and 1
	// ----------------------------------------
	tmode_t m0, m1;
	logic   t0split, en0, en1, ev0, ev1, step0, step0h, step1, ovf0, ovf1;
	cnt_t   c0, c1;

	// One count step for modes 0 to 3
	function automatic cnt_t step_cnt(input tmode_t m, input logic [7:0] hi, lo);
		cnt_t r;
		r.ovf = 1'b0;
		r.hi  = hi;
		r.lo  = lo;
		unique case (m)
			MODE_13B: begin                                        // [RQ6]
				r.lo = {lo[7:LO5_W], lo[LO5_W-1:0] + PRE_ONE};
				if (&lo[LO5_W-1:0]) begin                           // [RQ7]
					r.hi  = hi + BYTE_ONE;
					r.ovf = &hi;
				end
			end
			MODE_16B: begin                                        // [RQ9]
				{r.hi, r.lo} = {hi, lo} + WORD_ONE;
				r.ovf = &{hi, lo};
			end
			MODE_RLD: begin                                        // [RQ10]
				r.lo  = (&lo) ? hi : lo + BYTE_ONE;
				r.ovf = &lo;
			end
			MODE_SPLIT: begin                                      // [RQ12]
				r.lo  = lo + BYTE_ONE;
				r.ovf = &lo;
			end
		endcase
		return r;
	endfunction : step_cnt

	assign m0      = tmode_t'(timer_mode_reg_q[MODE0_LSB +: 2]);          // [RQ20]
	assign m1      = tmode_t'(timer_mode_reg_q[MODE1_LSB +: 2]);          // [RQ20]
	assign t0split = (m0 == MODE_SPLIT);
	// Source select: pin edge or internal tick
	assign ev0 = timer_mode_reg_q[CT0_BIT] ? (fall[0] & is_c3) : int_tick(ck_q[T0M_BIT], ticks); // [RQ4]
	assign ev1 = timer_mode_reg_q[CT1_BIT] ? (fall[1] & is_c3) : int_tick(ck_q[T1M_BIT], ticks); // [RQ4]
	assign en0 = tr0_q & (~timer_mode_reg_q[GATE0_BIT] | ext_irq_pin_a);   // [RQ8]
	// Second timer runs without its run bit while first is split
	assign en1 = (t0split | tr1_q) & (~timer_mode_reg_q[GATE1_BIT] | ext_irq_pin_b); // [RQ8] [RQ13]
	assign step0  = en0 & ev0;
	assign step0h = t0split & tr1_q & int_tick(ck_q[T0M_BIT], ticks); // [RQ12]
	assign step1  = en1 & ev1 & (m1 != MODE_SPLIT);             // [RQ11]
	assign c0     = step_cnt(m0, t0_high_byte_q, t0_low_byte_q);
	assign c1     = step_cnt(m1, t1_high_byte_q, t1_low_byte_q);
	assign ovf0   = step0 & c0.ovf;
	assign ovf1   = t0split ? (step0h & (&t0_high_byte_q)) : (step1 & c1.ovf); // [RQ13]

	// Counts and flags of timers 0 and 1
	always_comb begin
		t0_low_byte_d  = t0_low_byte_q;
		t0_high_byte_d = t0_high_byte_q;
		t1_low_byte_d  = t1_low_byte_q;
		t1_high_byte_d = t1_high_byte_q;
		if (step0) begin                                         // [RQ3]
			t0_low_byte_d  = c0.lo;
			t0_high_byte_d = c0.hi;
		end
		if (step0h) begin
			t0_high_byte_d = t0_high_byte_q + BYTE_ONE;            // [RQ12]
		end
		if (step1) begin
			t1_low_byte_d  = c1.lo;
			t1_high_byte_d = c1.hi;
		end
		if (wr_at(ADDR_T0LO)) t0_low_byte_d = reg_wdata;         // [RQ21]
		if (wr_at(ADDR_T0HI)) t0_high_byte_d = reg_wdata;        // [RQ21]
		if (wr_at(ADDR_T1LO)) t1_low_byte_d = reg_wdata;         // [RQ21]
		if (wr_at(ADDR_T1HI)) t1_high_byte_d = reg_wdata;        // [RQ21]
		tr0_d = wr_at(ADDR_TCTL) ? reg_wdata[TR0_BIT] : tr0_q;
		tr1_d = wr_at(ADDR_TCTL) ? reg_wdata[TR1_BIT] : tr1_q;
		tf0_d = tf0_q & ~t0_irq_ack;                             // [RQ18]
		tf1_d = tf1_q & ~t1_irq_ack;                             // [RQ18]
		if (wr_at(ADDR_TCTL)) begin                              // [RQ21]
			tf0_d = reg_wdata[TF0_BIT];
			tf1_d = reg_wdata[TF1_BIT];
		end
		// Hardware set wins over any clear
		if (ovf0) tf0_d = 1'b1;                                  // [RQ7] [RQ9]
		if (ovf1) tf1_d = 1'b1;                                  // [RQ12]
	end

	// ----------------------------------------
	// Timer 2
	// ----------------------------------------
	logic ev2, step2, ovf2, cap_ev;
	assign ev2    = ct2_q ? (fall[2] & is_c3) : int_tick(ck_q[T2M_BIT], ticks); // [RQ14]
	assign step2  = tr2_q & ev2;                                // [RQ14]
	assign ovf2   = step2 & (&{t2_high_byte_q, t2_low_byte_q});  // [RQ15]
	assign cap_ev = cprl_q & exen_q & fall[3] & is_c3;          // [RQ16]

	// Count, capture and flags of timer 2
	always_comb begin
		{t2_high_byte_d, t2_low_byte_d} = {t2_high_byte_q, t2_low_byte_q};
		capture_low_byte_d  = capture_low_byte_q;
		capture_high_byte_d = capture_high_byte_q;
		if (step2) begin                                         // [RQ15]
			{t2_high_byte_d, t2_low_byte_d} = {t2_high_byte_q, t2_low_byte_q} + WORD_ONE;
		end
		if (cap_ev) begin                                        // [RQ16]
			capture_low_byte_d  = t2_low_byte_q;
			capture_high_byte_d = t2_high_byte_q;
			if (clrc_q) {t2_high_byte_d, t2_low_byte_d} = WORD_RST; // [RQ17]
		end
		if (wr_at(ADDR_T2LO)) t2_low_byte_d = reg_wdata;         // [RQ21]
		if (wr_at(ADDR_T2HI)) t2_high_byte_d = reg_wdata;        // [RQ21]
		if (wr_at(ADDR_CAPLO)) capture_low_byte_d = reg_wdata;   // [RQ21]
		if (wr_at(ADDR_CAPHI)) capture_high_byte_d = reg_wdata;  // [RQ21]
		tf2_d  = wr_at(ADDR_T2CTL) ? reg_wdata[TF2_BIT] : tf2_q;  // [RQ19]
		t2_external_flag_d = wr_at(ADDR_T2CTL) ? reg_wdata[T2_EXTERNAL_FLAG_BIT] : t2_external_flag_q;
		if (ovf2) tf2_d = 1'b1;                                  // [RQ15]
		if (cap_ev) t2_external_flag_d = 1'b1;                               // [RQ16]
		t2irq_d = tf2_d | t2_external_flag_d;                                // [RQ19]
	end

	// ----------------------------------------
	// Control registers and read port
	// ----------------------------------------
	always_comb begin
		timer_mode_reg_d = wr_at(ADDR_TIMER_MODE_REG) ? reg_wdata : timer_mode_reg_q;
		ck_d   = wr_at(ADDR_CKCTL) ? reg_wdata : ck_q;
		exen_d = wr_at(ADDR_T2CTL) ? reg_wdata[EXEN_BIT] : exen_q;
		tr2_d  = wr_at(ADDR_T2CTL) ? reg_wdata[TR2_BIT] : tr2_q;
		ct2_d  = wr_at(ADDR_T2CTL) ? reg_wdata[CT2_BIT] : ct2_q;
		cprl_d = wr_at(ADDR_T2CTL) ? reg_wdata[CPRL_BIT] : cprl_q;
		clrc_d = wr_at(ADDR_T2_MODE_REG) ? reg_wdata[CLRC_BIT] : clrc_q;
		rd_d   = BYTE_RST;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_TIMER_MODE_REG:  rd_d = timer_mode_reg_q;
				ADDR_CKCTL: rd_d = ck_q;
				ADDR_T0LO:  rd_d = t0_low_byte_q;
				ADDR_T0HI:  rd_d = t0_high_byte_q;
				ADDR_T1LO:  rd_d = t1_low_byte_q;
				ADDR_T1HI:  rd_d = t1_high_byte_q;
				ADDR_T2LO:  rd_d = t2_low_byte_q;
				ADDR_T2HI:  rd_d = t2_high_byte_q;
				ADDR_CAPLO: rd_d = capture_low_byte_q;
				ADDR_CAPHI: rd_d = capture_high_byte_q;
				ADDR_T2_MODE_REG: rd_d[CLRC_BIT] = clrc_q;
				ADDR_TCTL: begin
					rd_d[TF1_BIT] = tf1_q;
					rd_d[TR1_BIT] = tr1_q;
					rd_d[TF0_BIT] = tf0_q;
					rd_d[TR0_BIT] = tr0_q;
				end
				ADDR_T2CTL: begin
					rd_d[TF2_BIT]  = tf2_q;
					rd_d[T2_EXTERNAL_FLAG_BIT] = t2_external_flag_q;
					rd_d[EXEN_BIT] = exen_q;
					rd_d[TR2_BIT]  = tr2_q;
					rd_d[CT2_BIT]  = ct2_q;
					rd_d[CPRL_BIT] = cprl_q;
				end
				default: rd_d = BYTE_RST;                        // Unmapped reads zero
			endcase
		end
	end

	// Register all counts, flags and control state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_mode_reg_q <= BYTE_RST;
			ck_q   <= BYTE_RST;                                    // [RQ5]
			rd_q   <= BYTE_RST;
			t0_low_byte_q <= BYTE_RST;
			t0_high_byte_q <= BYTE_RST;
			t1_low_byte_q <= BYTE_RST;
			t1_high_byte_q <= BYTE_RST;
			t2_low_byte_q <= BYTE_RST;
			t2_high_byte_q <= BYTE_RST;
			capture_low_byte_q <= BYTE_RST;
			capture_high_byte_q <= BYTE_RST;
			{tf0_q, tf1_q, tr0_q, tr1_q, tf2_q, t2_external_flag_q, t2irq_q} <= '0;
			{exen_q, tr2_q, ct2_q, cprl_q, clrc_q} <= '0;
		end else begin
			timer_mode_reg_q <= timer_mode_reg_d;
			ck_q   <= ck_d;
			rd_q   <= rd_d;
			t0_low_byte_q <= t0_low_byte_d;
			t0_high_byte_q <= t0_high_byte_d;
			t1_low_byte_q <= t1_low_byte_d;
			t1_high_byte_q <= t1_high_byte_d;
			t2_low_byte_q <= t2_low_byte_d;
			t2_high_byte_q <= t2_high_byte_d;
			capture_low_byte_q <= capture_low_byte_d;
			capture_high_byte_q <= capture_high_byte_d;
			{tf0_q, tf1_q, tr0_q, tr1_q} <= {tf0_d, tf1_d, tr0_d, tr1_d};
			{tf2_q, t2_external_flag_q, t2irq_q} <= {tf2_d, t2_external_flag_d, t2irq_d};
			{exen_q, tr2_q, ct2_q, cprl_q, clrc_q} <= {exen_d, tr2_d, ct2_d, cprl_d, clrc_d};
		end
	end

	assign reg_rdata = rd_q;
	assign t0_irq    = tf0_q;
	assign t1_irq    = tf1_q;
	assign t2_irq    = t2irq_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	AST_SAMPLE_C4: assert property ((phase_q != PH_C4) |=> $stable(samp_q)) // [RQ1]
		else $error("pin sampled outside C4");
	AST_UPDATE_C3: assert property (!reg_wr && !is_c3 |=> $stable({t0_high_byte_q,
		t0_low_byte_q, t2_high_byte_q, t2_low_byte_q})) // [RQ3]
		else $error("count changed outside C3");
	AST_SLOW_RATE: assert property (tick_slow |-> ##4 !tick_slow ##4 !tick_slow ##4 tick_slow) // [RQ5]
		else $error("slow tick not every third machine cycle");
	AST_M0_OVF: assert property (step0 && m0 == MODE_13B && (&t0_high_byte_q)
		&& (&t0_low_byte_q[LO5_W-1:0]) |=> tf0_q && t0_high_byte_q == BYTE_RST) // [RQ7]
		else $error("mode 0 overflow missed");
	AST_GATE: assert property (!reg_wr && !t0split && timer_mode_reg_q[GATE0_BIT] && !ext_irq_pin_a
		|=> $stable({t0_high_byte_q, t0_low_byte_q})) // [RQ8]
		else $error("gated timer counted");
	AST_M1_OVF: assert property (step0 && m0 == MODE_16B && (&{t0_high_byte_q, t0_low_byte_q})
		|=> tf0_q && {t0_high_byte_q, t0_low_byte_q} == WORD_RST) // [RQ9]
		else $error("mode 1 overflow missed");
	AST_RELOAD: assert property (!reg_wr && step0 && m0 == MODE_RLD && (&t0_low_byte_q)
		|=> t0_low_byte_q == $past(t0_high_byte_q) && $stable(t0_high_byte_q)) // [RQ10]
		else $error("mode 2 reload wrong");
	AST_FREEZE: assert property (!reg_wr && m1 == MODE_SPLIT
		|=> $stable({t1_high_byte_q, t1_low_byte_q})) // [RQ11]
		else $error("second timer moved in mode 3");
	AST_CAPTURE: assert property (cap_ev && !reg_wr |=> t2_external_flag_q && t2_irq
		&& {capture_high_byte_q, capture_low_byte_q} == $past({t2_high_byte_q, t2_low_byte_q})) // [RQ16]
		else $error("capture wrong");
	AST_CLR_CAP: assert property (cap_ev && clrc_q && !reg_wr
		|=> {t2_high_byte_q, t2_low_byte_q} == WORD_RST) // [RQ17]
		else $error("count not cleared after capture");
	AST_ACK: assert property (t0_irq_ack && !ovf0 && !reg_wr |=> !t0_irq) // [RQ18]
		else $error("ack did not clear flag");

	COV_SPLIT_HI: cover property (step0h && (&t0_high_byte_q) ##1 t1_irq);
	COV_CAPTURE: cover property (cap_ev && clrc_q);
	COV_T1_RELOAD: cover property (step1 && m1 == MODE_RLD && c1.ovf);
endmodule : dual_timer_with_capture_timer

//--- tb/pin_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Far-side pin driver
// ----------------------------------------
module pin_model
	import dual_timer_pkg::*;
#(
	parameter int HALF = 24
)(
	// Clock
	input  wire logic       ref_clk,
	// Pulse request
	input  wire logic       go,
	input  wire logic [1:0] sel,
	input  wire logic [3:0] n,
	// Pins and status
	output logic      [3:0] pins,
	output logic            busy
);
	// Pins rest high like pulled-up port lines, then falling pulses,
	// each level held a full half period
	initial begin
		pins = 4'hF;
		busy = 1'b0;
		forever begin
			@(posedge ref_clk);
			if (go) begin
				busy <= 1'b1;
				for (int i = 0; i < n; i++) begin
					repeat (HALF) @(posedge ref_clk);
					pins[sel] <= 1'b0;
					repeat (HALF) @(posedge ref_clk);
					pins[sel] <= 1'b1;
				end
				busy <= 1'b0;
			end
		end
	end
endmodule : pin_model

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import dual_timer_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        ref_clk = 1'b0, rst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	logic        ext_irq_pin_a = 1'b0, ext_irq_pin_b = 1'b0;
	logic        t0_irq_ack = 1'b0, t1_irq_ack = 1'b0;
	logic        t0_irq, t1_irq, t2_irq, pgo = 1'b0, pbusy;
	logic [1:0]  psel = 2'h0;
	logic [3:0]  pn = 4'h0, pins;
	logic [23:0] exp_q[$];
	logic [23:0] e_cur;
	logic [15:0] rnd = 16'h8110;
	int          miscompares = 0, n_compared = 0, cycles = 0;

	// Clock
	always #2.5 ref_clk = ~ref_clk;

	dual_timer_with_capture_timer uut (
		.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.count_pin_a(pins[0]), .count_pin_b(pins[1]), .count_pin_c(pins[2]),
		.t2_trigger_pin(pins[3]), .ext_irq_pin_a(ext_irq_pin_a),
		.ext_irq_pin_b(ext_irq_pin_b), .t0_irq_ack(t0_irq_ack), .t1_irq_ack(t1_irq_ack),
		.t0_irq(t0_irq), .t1_irq(t1_irq), .t2_irq(t2_irq)
	);

	pin_model pins_far (
		.ref_clk(ref_clk), .go(pgo), .sel(psel), .n(pn), .pins(pins), .busy(pbusy)
	);

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	function automatic logic [15:0] xs(input logic [15:0] s);
		s ^= s << 7;
		s ^= s >> 9;
		s ^= s << 8;
		return s;
	endfunction : xs

	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	task automatic summarize();
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	// Read data stands only in the cycle after the strobe
	always @(posedge ref_clk) rd_d <= reg_rd;
	always @(negedge ref_clk) begin
		if (rd_d) begin
			e_cur = exp_q.pop_front();
			chk($sformatf("reg %h", e_cur[23:16]), {8'h00, reg_rdata & e_cur[15:8]},
				{8'h00, e_cur[7:0]});
		end
	end

	// Hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end

	// ----------------------------------------
	// Bus and pin tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m = 8'hFF);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		exp_q.push_back({a, m, x & m});
		@(posedge ref_clk);
	endtask : rd

	task automatic idle(input int k);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (k) @(posedge ref_clk);
	endtask : idle

	// Run gate open for exactly d clocks, flags checked before the closing write
	task automatic run_win(input logic [7:0] a, input logic [7:0] on, input logic [7:0] off,
		input int d, input logic [2:0] x);
		wr(a, on);
		idle(d - 4);
		chk_irq(x);
		wr(a, off);
		idle(3);
	endtask : run_win

	task automatic chk_irq(input logic [2:0] x);
		idle(2);
		@(negedge ref_clk);
		chk("irq", {13'h0, t2_irq, t1_irq, t0_irq}, {13'h0, x});
		@(posedge ref_clk);
	endtask : chk_irq

	task automatic ack(input logic [1:0] w);
		t0_irq_ack <= w[0];
		t1_irq_ack <= w[1];
		@(posedge ref_clk);
		t0_irq_ack <= 1'b0;
		t1_irq_ack <= 1'b0;
		@(posedge ref_clk);
	endtask : ack

	task automatic pulse(input logic [1:0] s, input logic [3:0] k);
		int w;
		w = 0;
		psel <= s;
		pn <= k;
		pgo <= 1'b1;
		@(posedge ref_clk);
		pgo <= 1'b0;
		@(posedge ref_clk);
		while (pbusy && w < 2000) begin
			@(posedge ref_clk);
			w++;
		end
		// Pin model stuck busy
		if (pbusy) begin
			miscompares++;
			summarize();
		end
		idle(12);
	endtask : pulse

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] la;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		for (int a = 0; a < 14; a++) rd(a[7:0], 8'h00);
		wr(8'h0D, 8'hFF);
		rd(8'h0D, 8'h00);
		// Mode 1 overflow, fast and slow rates side by side
		wr(ADDR_TIMER_MODE_REG, 8'h11);
		wr(ADDR_CKCTL, 8'h08);
		wr(ADDR_T0LO, 8'hFE);
		wr(ADDR_T0HI, 8'hFF);
		wr(ADDR_T1LO, 8'hFE);
		wr(ADDR_T1HI, 8'hFF);
		run_win(ADDR_TCTL, 8'h50, 8'h20, 12, 3'b001);
		rd(ADDR_T0LO, 8'h01);
		rd(ADDR_T0HI, 8'h00);
		rd(ADDR_T1LO, 8'hFF);
		chk_irq(3'b001);
		ack(2'b01);
		chk_irq(3'b000);
		wr(ADDR_TCTL, 8'hA0);
		chk_irq(3'b011);
		ack(2'b11);
		chk_irq(3'b000);
		// Mode 0 carry with upper low bits set, then 13-bit wrap
		wr(ADDR_TIMER_MODE_REG, 8'h00);
		wr(ADDR_T0LO, 8'hFF);
		wr(ADDR_T0HI, 8'h05);
		run_win(ADDR_TCTL, 8'h10, 8'h00, 4, 3'b000);
		rd(ADDR_T0HI, 8'h06);
		rd(ADDR_T0LO, 8'h00, 8'h1F);
		wr(ADDR_T0LO, 8'h1F);
		wr(ADDR_T0HI, 8'hFF);
		run_win(ADDR_TCTL, 8'h10, 8'h20, 8, 3'b001);
		rd(ADDR_T0HI, 8'h00);
		chk_irq(3'b001);
		ack(2'b01);
		// Mode 2 reload from a random high byte
		rnd = xs(rnd);
		wr(ADDR_TIMER_MODE_REG, 8'h02);
		wr(ADDR_T0LO, 8'hFF);
		wr(ADDR_T0HI, rnd[7:0]);
		run_win(ADDR_TCTL, 8'h10, 8'h20, 8, 3'b001);
		rd(ADDR_T0LO, (&rnd[7:0]) ? rnd[7:0] : rnd[7:0] + 8'h01);
		rd(ADDR_T0HI, rnd[7:0]);
		chk_irq(3'b001);
		ack(2'b01);
		// Gate pins block and release counting
		wr(ADDR_CKCTL, 8'h18);
		for (int i = 0; i < 2; i++) begin
			la = i ? ADDR_T1LO : ADDR_T0LO;
			wr(ADDR_TIMER_MODE_REG, i ? 8'h90 : 8'h09);
			ext_irq_pin_a <= 1'b0;
			ext_irq_pin_b <= 1'b0;
			wr(la, 8'h00);
			run_win(ADDR_TCTL, i ? 8'h40 : 8'h10, 8'h00, 24, 3'b000);
			rd(la, 8'h00);
			ext_irq_pin_a <= 1'b1;
			ext_irq_pin_b <= 1'b1;
			run_win(ADDR_TCTL, i ? 8'h40 : 8'h10, 8'h00, 24, 3'b000);
			rd(la, 8'h06);
		end
		// Pin counting on both timers
		wr(ADDR_TIMER_MODE_REG, 8'h55);
		wr(ADDR_T0LO, 8'h00);
		wr(ADDR_T1LO, 8'h00);
		wr(ADDR_TCTL, 8'h50);
		pulse(2'd0, 4'd3);
		pulse(2'd1, 4'd2);
		wr(ADDR_TCTL, 8'h00);
		rd(ADDR_T0LO, 8'h03);
		rd(ADDR_T1LO, 8'h02);
		// Split mode: second timer frozen, then running without its run bit
		wr(ADDR_TIMER_MODE_REG, 8'h33);
		wr(ADDR_T0LO, 8'h00);
		wr(ADDR_T0HI, 8'hFF);
		wr(ADDR_T1LO, 8'h00);
		wr(ADDR_T1HI, 8'h00);
		run_win(ADDR_TCTL, 8'h50, 8'h80, 24, 3'b010);
		wr(ADDR_TIMER_MODE_REG, 8'h13);
		idle(23);
		wr(ADDR_TIMER_MODE_REG, 8'h33);
		idle(3);
		rd(ADDR_T0LO, 8'h06);
		rd(ADDR_T0HI, 8'h05);
		rd(ADDR_T1LO, 8'h06);
		chk_irq(3'b010);
		ack(2'b10);
		// Third timer wrap, capture with clear, pin source
		wr(ADDR_CKCTL, 8'h20);
		wr(ADDR_T2LO, 8'hFE);
		wr(ADDR_T2HI, 8'hFF);
		run_win(ADDR_T2CTL, 8'h05, 8'h81, 12, 3'b100);
		rd(ADDR_T2LO, 8'h01);
		rd(ADDR_T2CTL, 8'h81);
		chk_irq(3'b100);
		rnd = xs(rnd);
		wr(ADDR_T2LO, rnd[7:0]);
		wr(ADDR_T2HI, rnd[15:8]);
		wr(ADDR_T2_MODE_REG, 8'h08);
		wr(ADDR_T2CTL, 8'h09);
		chk_irq(3'b000);
		pulse(2'd3, 4'd1);
		rd(ADDR_CAPLO, rnd[7:0]);
		rd(ADDR_CAPHI, rnd[15:8]);
		rd(ADDR_T2LO, 8'h00);
		rd(ADDR_T2HI, 8'h00);
		rd(ADDR_T2CTL, 8'h49);
		chk_irq(3'b100);
		wr(ADDR_T2CTL, 8'h06);
		pulse(2'd2, 4'd2);
		wr(ADDR_T2CTL, 8'h00);
		rd(ADDR_T2LO, 8'h02);
		chk_irq(3'b000);
		idle(4);
		summarize();
	end
endmodule : tb_top
